// ===== hdl/conv_ctrl.v
// converter mode, load measurement and sync clock control with avalon register slave
`timescale 1ns/1ps
`include "conv_ctrl_defs.vh"
module conv_ctrl #(
    parameter MEAS_CYCLES = `MEAS_CYC,
    parameter BOOT_CYCLES = `BOOT_CYC
) (
    // clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // avalon-mm slave
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // analog side
    input  wire [8:0]  load_code_i,
    input  wire        ext_sync_clock_pin_i,
    input  wire        converter_enable_i,
    input  wire        otp_fpwm0_i,
    input  wire        otp_fpwm1_i,
    // converter control
    output reg  [1:0]  core_pwm_o,
    output reg         use_ext_clock_o,
    output reg  [3:0]  dither_step_o,
    output reg         meas_busy_o,
    output reg         irq_o,
    output reg         ready_o
);
    localparam ST_BOOT = 2'h0;
    localparam ST_STBY = 2'h1;
    localparam ST_ACT  = 2'h2;
    localparam [18:0] MEAS_N = MEAS_CYCLES[18:0];
    localparam [18:0] BOOT_N = BOOT_CYCLES[18:0];

    // cycles of clk_sys per link period for nominal n MHz: 200/n
    function [8:0] nom_cyc;
        input [4:0] sel;
        begin
            nom_cyc = (sel == 5'h0) ? 9'd200 : (9'd200 / {4'h0, sel});
        end
    endfunction

    // nominal scaled by pct/100; product kept at 17 bits so 200 * 143 cannot wrap
    function [9:0] scale_pct;
        input [8:0]  n;
        input [7:0]  pct;
        reg   [16:0] prod;
        begin
            prod      = ({8'h0, n} * {9'h0, pct}) / 17'h64;
            scale_pct = prod[9:0];
        end
    endfunction

    reg [1:0]  state_reg;
    reg [18:0] boot_cnt_reg;
    reg        meas_sel_reg;
    reg [18:0] meas_cnt_reg;
    reg [8:0]  result_reg;
    reg [1:0]  int_reg;
    reg [1:0]  mask_reg;
    reg        dither_en_reg;
    reg [7:0]  pll_ctrl_reg;
    reg [1:0]  fpwm_reg;
    reg [1:0]  heavy_reg;
    reg        s1_reg;
    reg        s2_reg;
    reg        s3_reg;
    reg [9:0]  per_cnt_reg;
    reg        ext_ok_reg;
    reg [3:0]  dither_reg;
    reg        dither_dir_reg;

    wire       wr        = avs_write_i & ~avs_waitrequest_o & (state_reg != ST_BOOT);
    // answer edge: a request seen while still waiting; read data is launched with it
    wire       ans       = (avs_read_i | avs_write_i) & avs_waitrequest_o & (state_reg != ST_BOOT);
    wire       meas_start = wr & (avs_address_i == `A_MEAS_SEL);
    wire       heavy_now = ({10'h0, load_code_i} * `LSB_MA) >= `HEAVY_LOAD_MA;
    wire       pll_en    = pll_ctrl_reg[`B_PLL_EN];
    wire [8:0] nom       = nom_cyc(pll_ctrl_reg[4:0]);
    // valid period window: freq in 0.7..1.1 of nominal -> period nom/1.1 .. nom/0.7
    wire [9:0] per_min   = scale_pct(nom, `PER_MIN_PCT);
    wire [9:0] per_max   = scale_pct(nom, `PER_MAX_PCT);
    wire       rise      = s2_reg & ~s3_reg;
    wire       meas_done = meas_busy_o & ~meas_start & (meas_cnt_reg == MEAS_N - 19'h1);
    wire       ext_pres_next = rise ? ((per_cnt_reg >= per_min) && (per_cnt_reg <= per_max))
                                    : (per_cnt_reg > per_max ? 1'b0 : ext_ok_reg);
    wire       go_active = (state_reg == ST_STBY) & converter_enable_i;
    wire       boot_end  = (state_reg == ST_BOOT) & (boot_cnt_reg == BOOT_N - 19'h1);
    wire       sync_evt  = pll_en & ((ext_pres_next != ext_ok_reg)
                                     | ((boot_end | go_active) & ~ext_pres_next));
    reg  [1:0] int_next;
    reg  [31:0] rdata;

    always @* begin
        int_next = int_reg;
        if (wr && avs_address_i == `A_INT_TOP) begin
            int_next = int_reg & ~avs_writedata_i[1:0];
        end
        // set beats clear in the same cycle
        if (meas_done) begin
            int_next[`B_INT_MEAS] = 1'b1;
        end
        if (sync_evt) begin
            int_next[`B_INT_SYNC] = 1'b1;
        end
    end

    always @* begin
        rdata = 32'h0;
        case (avs_address_i)
            `A_MEAS_SEL: rdata = {31'h0, meas_sel_reg};
            `A_LOAD_LO:  rdata = {24'h0, result_reg[7:0]};
            `A_LOAD_HI:  rdata = {31'h0, result_reg[8]};
            `A_INT_TOP:  rdata = {30'h0, int_reg};
            `A_MASK_TOP: rdata = {30'h0, mask_reg};
            `A_CONFIG:   rdata = {31'h0, dither_en_reg};
            `A_PLL_CTRL: rdata = {24'h0, pll_ctrl_reg};
            `A_CORE0:    rdata = {31'h0, fpwm_reg[0]};
            `A_CORE1:    rdata = {31'h0, fpwm_reg[1]};
            `A_STATUS:   rdata = {23'h0, state_reg == ST_ACT, 5'h0, meas_busy_o, ext_ok_reg,
                                  use_ext_clock_o};
            default:     rdata = 32'h0;
        endcase
    end

    // link clock sampling; s1 feeds only s2
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            s1_reg      <= 1'b0;
            s2_reg      <= 1'b0;
            s3_reg      <= 1'b0;
            per_cnt_reg <= 10'h0;
            ext_ok_reg  <= 1'b0;
        end else begin
            s1_reg     <= ext_sync_clock_pin_i;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            ext_ok_reg <= ext_pres_next;
            if (rise) begin
                per_cnt_reg <= 10'h1;
            end else if (per_cnt_reg != 10'h3ff) begin
                per_cnt_reg <= per_cnt_reg + 10'h1;
            end
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg         <= ST_BOOT;
            boot_cnt_reg      <= 19'h0;
            meas_sel_reg      <= 1'b0;
            meas_cnt_reg      <= 19'h0;
            result_reg        <= 9'h0;
            int_reg           <= 2'h0;
            mask_reg          <= `RST_MASK_TOP;
            dither_en_reg     <= `RST_CONFIG;
            pll_ctrl_reg      <= `RST_PLL_CTRL;
            fpwm_reg          <= 2'h0;
            heavy_reg         <= 2'h0;
            dither_reg        <= 4'h0;
            dither_dir_reg    <= 1'b0;
            avs_readdata_o    <= 32'h0;
            avs_waitrequest_o <= 1'b1;
            core_pwm_o        <= 2'h0;
            use_ext_clock_o   <= 1'b0;
            dither_step_o     <= 4'h0;
            meas_busy_o       <= 1'b0;
            irq_o             <= 1'b0;
            ready_o           <= 1'b0;
        end else begin
            int_reg <= int_next;
            // one wait cycle per access; held off until defaults are loaded
            avs_waitrequest_o <= ~ans;
            if (ans && avs_read_i) begin
                avs_readdata_o <= rdata;
            end
            case (state_reg)
                ST_BOOT: begin
                    boot_cnt_reg <= boot_cnt_reg + 19'h1;
                    if (boot_end) begin
                        fpwm_reg  <= {otp_fpwm1_i, otp_fpwm0_i};
                        state_reg <= ST_STBY;
                        ready_o   <= 1'b1;
                    end
                end
                ST_STBY: if (converter_enable_i) state_reg <= ST_ACT;
                ST_ACT:  if (!converter_enable_i) state_reg <= ST_STBY;
                default: state_reg <= ST_BOOT;
            endcase
            if (wr) begin
                case (avs_address_i)
                    `A_MEAS_SEL: meas_sel_reg  <= avs_writedata_i[0];
                    `A_MASK_TOP: mask_reg      <= avs_writedata_i[1:0];
                    `A_CONFIG:   dither_en_reg <= avs_writedata_i[0];
                    `A_PLL_CTRL: pll_ctrl_reg  <= {avs_writedata_i[7], 2'h0,
                                                   avs_writedata_i[4:0]};
                    `A_CORE0:    fpwm_reg[0]   <= avs_writedata_i[`B_FPWM];
                    `A_CORE1:    fpwm_reg[1]   <= avs_writedata_i[`B_FPWM];
                    default: ;
                endcase
            end
            // apart from the write decode, so other writes never stall a measurement
            if (meas_start) begin
                meas_busy_o  <= 1'b1;
                meas_cnt_reg <= 19'h0;
            end else if (meas_busy_o) begin
                meas_cnt_reg <= meas_cnt_reg + 19'h1;
                if (meas_done) begin
                    meas_busy_o <= 1'b0;
                    result_reg  <= load_code_i;
                end
            end
            // heavy load from the shared sense code of the selected core
            heavy_reg[meas_sel_reg] <= heavy_now;
            core_pwm_o[0] <= fpwm_reg[0] | heavy_reg[0]
                             | (meas_busy_o & ~meas_sel_reg);
            core_pwm_o[1] <= fpwm_reg[1] | heavy_reg[1] | (meas_busy_o & meas_sel_reg);
            use_ext_clock_o <= pll_en & ext_ok_reg;
            if (dither_en_reg && !pll_en) begin
                // triangle sweep between 0 and 15
                dither_reg <= dither_dir_reg ? dither_reg - 4'h1 : dither_reg + 4'h1;
                if (dither_reg == `DITHER_SPAN - 4'h1 && !dither_dir_reg) dither_dir_reg <= 1'b1;
                if (dither_reg == 4'h1 && dither_dir_reg) dither_dir_reg <= 1'b0;
            end else begin
                dither_reg     <= 4'h0;
                dither_dir_reg <= 1'b0;
            end
            dither_step_o <= dither_reg;
            irq_o <= |(int_next & ~mask_reg);
        end
    end
endmodule // conv_ctrl

// ===== hdl/conv_ctrl_defs.vh
// register offsets, field positions, reset values and timing counts for the converter control
`ifndef CONV_CTRL_DEFS_VH
`define CONV_CTRL_DEFS_VH
`define A_MEAS_SEL      4'h0
`define A_LOAD_LO       4'h1
`define A_LOAD_HI       4'h2
`define A_INT_TOP       4'h3
`define A_MASK_TOP      4'h4
`define A_CONFIG        4'h5
`define A_PLL_CTRL      4'h6
`define A_CORE0         4'h7
`define A_CORE1         4'h8
`define A_STATUS        4'h9
`define B_INT_MEAS      0
`define B_INT_SYNC      1
`define B_PLL_EN        7
`define B_FPWM          0
`define B_ACTIVE        8
`define RST_MASK_TOP    2'h0
`define RST_CONFIG      1'h0
`define RST_PLL_CTRL    8'h00
`define MEAS_TIME_NS    50000
`define CLK_PERIOD_NS   5
`define MEAS_CYC        (`MEAS_TIME_NS / `CLK_PERIOD_NS)
`define BOOT_TIME_NS    1200000
`define BOOT_CYC        (`BOOT_TIME_NS / `CLK_PERIOD_NS)
`define HEAVY_LOAD_MA   600
`define LSB_MA          20
`define SYNC_TOL_LO_PCT 70
`define SYNC_TOL_HI_PCT 110
// valid link period as percent of nominal: 1/1.1 and 1/0.7
`define PER_MIN_PCT     8'h5b
`define PER_MAX_PCT     8'h8f
`define DITHER_SPAN     4'hf
`endif

// ===== tb/conv_ctrl_assertions.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module conv_ctrl_check #(
    parameter MEAS_CYCLES = 10
) (
    input wire        clk_sys_i,
    input wire        rst_i,
    input wire [3:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire        avs_waitrequest_o,
    input wire [1:0]  core_pwm_o,
    input wire        use_ext_clock_o,
    input wire [3:0]  dither_step_o,
    input wire        meas_busy_o,
    input wire        irq_o,
    input wire        ready_o
);
    localparam int MEAS_MAX = MEAS_CYCLES + 4;
    logic       wr_ok;
    logic       pll_q;
    logic [1:0] mask_q;
    logic [2:0] pll_hist;
    logic [2:0] mask_hist;
    assign wr_ok = avs_write_i && !avs_waitrequest_o;
    // shadow registers; history covers the output latency
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            pll_q <= 1'b0;
            mask_q <= 2'h0;
            pll_hist <= 3'h0;
            mask_hist <= 3'h0;
        end else begin
            if (wr_ok && avs_address_i == 4'h6) pll_q <= avs_writedata_i[7];
            if (wr_ok && avs_address_i == 4'h4) mask_q <= avs_writedata_i[1:0];
            pll_hist <= {pll_hist[1:0], pll_q};
            mask_hist <= {mask_hist[1:0], &mask_q};
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    boot_wait_a: assert property (!ready_o |-> avs_waitrequest_o)
        else $error("bus open before boot");
    ans_one_a: assert property (!avs_waitrequest_o |->
        ($past(avs_write_i) || $past(avs_read_i)) ##1 avs_waitrequest_o)
        else $error("bad bus answer");
    meas_start_a: assert property (wr_ok && avs_address_i == 4'h0
        |=> ##[0:2] meas_busy_o)
        else $error("measurement not started");
    meas_pwm_a: assert property (meas_busy_o && $past(meas_busy_o)
        |-> core_pwm_o != 2'h0)
        else $error("no pwm during measurement");
    meas_bound_a: assert property ($rose(meas_busy_o)
        |-> ##[1:MEAS_MAX] !meas_busy_o)
        else $error("measurement too long");
    meas_irq_a: assert property ($fell(meas_busy_o) && !mask_q[0] && !$past(mask_q[0])
        |-> ##[0:3] irq_o)
        else $error("no done interrupt");
    pll_off_a: assert property (!pll_q && pll_hist == 3'h0 |-> !use_ext_clock_o)
        else $error("external clock used with pll off");
    dither_off_a: assert property (pll_hist == 3'h7 |-> $stable(dither_step_o))
        else $error("dither with pll on");
    irq_mask_a: assert property (mask_hist == 3'h7 |-> !irq_o)
        else $error("masked interrupt raised");
endmodule // conv_ctrl_check
bind conv_ctrl conv_ctrl_check #(.MEAS_CYCLES(MEAS_CYCLES)) i_conv_ctrl_check (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_waitrequest_o(avs_waitrequest_o), .core_pwm_o(core_pwm_o),
    .use_ext_clock_o(use_ext_clock_o), .dither_step_o(dither_step_o),
    .meas_busy_o(meas_busy_o), .irq_o(irq_o), .ready_o(ready_o));

// ===== tb/ext_clock_src.sv
// external sync clock source for the bench
`timescale 1ns/1ps
module ext_clock_src (
    // control
    input  wire  run_i,
    // clock out
    output logic clk_o
);
    // 160 ns period sits inside the valid window of the 6 MHz setting
    // held low between bursts; odd offset keeps it unrelated to the system clock
    initial begin
        clk_o = 1'b0;
        #1.3;
        forever #80 clk_o = run_i ? ~clk_o : 1'b0;
    end
endmodule // ext_clock_src

// ===== tb/tb_buck_clock_sync_and_load_meas.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_buck_clock_sync_and_load_meas;
    logic        clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, run_clk;
    logic        ext_sync_clock_pin_i, converter_enable_i, otp_fpwm0_i, otp_fpwm1_i;
    logic        use_ext_clock_o, meas_busy_o, irq_o, ready_o;
    logic [3:0]  avs_address_i, dither_step_o, d;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    logic [8:0]  load_code_i;
    logic [1:0]  core_pwm_o;
    int          fails, cmp_count, cyc, n;
    conv_ctrl #(.MEAS_CYCLES(10), .BOOT_CYCLES(20)) i_conv_ctrl (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .load_code_i(load_code_i), .ext_sync_clock_pin_i(ext_sync_clock_pin_i),
        .converter_enable_i(converter_enable_i), .otp_fpwm0_i(otp_fpwm0_i),
        .otp_fpwm1_i(otp_fpwm1_i), .core_pwm_o(core_pwm_o), .use_ext_clock_o(use_ext_clock_o),
        .dither_step_o(dither_step_o), .meas_busy_o(meas_busy_o), .irq_o(irq_o),
        .ready_o(ready_o));
    ext_clock_src i_ext_clock_src (.run_i(run_clk), .clk_o(ext_sync_clock_pin_i));
    task automatic give_verdict;
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // held until waitrequest is seen low; data taken at that edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= v;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask
    task automatic t_boot;
        // host holds off all access until the block reports ready
        for (n = 0; n < 100 && ready_o !== 1'b1; n++) @(posedge clk_sys_i);
        cmp(ready_o, 1'b1);
        rchk(4'h4, 32'h0);
        rchk(4'h6, 32'h0);
        rchk(4'hf, 32'h0);
        rchk(4'h7, 32'h1);
        rchk(4'h8, 32'h0);
    endtask
    task automatic t_mode;
        bus(1'b1, 4'h7, 32'h0);
        load_code_i <= 9'h00a;
        repeat (4) @(posedge clk_sys_i);
        cmp(core_pwm_o[0], 1'b0);
        load_code_i <= 9'h01e;
        repeat (4) @(posedge clk_sys_i);
        cmp(core_pwm_o[0], 1'b1);
        load_code_i <= 9'h00a;
        bus(1'b1, 4'h8, 32'h1);
        rchk(4'h8, 32'h1);
        repeat (4) @(posedge clk_sys_i);
        cmp(core_pwm_o[1], 1'b1);
        bus(1'b1, 4'h8, 32'h0);
    endtask
    task automatic meas(input logic sel);
        bus(1'b1, 4'h0, {31'h0, sel});
        repeat (2) @(posedge clk_sys_i);
        cmp(meas_busy_o, 1'b1);
        cmp(core_pwm_o[sel], 1'b1);
        rchk(4'h0, {31'h0, sel});
    endtask
    task automatic t_meas;
        load_code_i <= 9'h1ab;
        meas(1'b1);
        for (n = 0; n < 100 && meas_busy_o !== 1'b0; n++) @(posedge clk_sys_i);
        rchk(4'h1, 32'hab);
        rchk(4'h2, 32'h1);
        rchk(4'h3, 32'h1);
        cmp(irq_o, 1'b1);
        bus(1'b1, 4'h3, 32'h1);
        bus(1'b1, 4'h4, 32'h1);
        // light load: only the running measurement can hold core 0 in pwm
        load_code_i <= 9'h005;
        meas(1'b0);
        rchk(4'h1, 32'hab);
        for (n = 0; n < 100 && meas_busy_o !== 1'b0; n++) @(posedge clk_sys_i);
        rchk(4'h2, 32'h0);
        rchk(4'h1, 32'h05);
        cmp(core_pwm_o[0], 1'b0);
        rchk(4'h3, 32'h1);
        cmp(irq_o, 1'b0);
        bus(1'b1, 4'h3, 32'h1);
    endtask
    task automatic t_sync;
        bus(1'b1, 4'h6, 32'h86);
        run_clk <= 1'b1;
        for (n = 0; n < 400 && use_ext_clock_o !== 1'b1; n++) @(posedge clk_sys_i);
        cmp(use_ext_clock_o, 1'b1);
        rchk(4'h9, 32'h3);
        rchk(4'h3, 32'h2);
        bus(1'b1, 4'h3, 32'h2);
        run_clk <= 1'b0;
        for (n = 0; n < 400 && use_ext_clock_o !== 1'b0; n++) @(posedge clk_sys_i);
        cmp(use_ext_clock_o, 1'b0);
        rchk(4'h3, 32'h2);
        bus(1'b1, 4'h3, 32'h2);
        converter_enable_i <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        rchk(4'h9, 32'h100);
        rchk(4'h3, 32'h2);
        bus(1'b1, 4'h3, 32'h2);
    endtask
    task automatic t_pll_off;
        bus(1'b1, 4'h6, 32'h6);
        bus(1'b1, 4'h5, 32'h1);
        run_clk <= 1'b1;
        d = dither_step_o;
        repeat (200) @(posedge clk_sys_i);
        cmp(use_ext_clock_o, 1'b0);
        cmp(dither_step_o !== d, 1'b1);
        rchk(4'h3, 32'h0);
        bus(1'b1, 4'h4, 32'h3);
        bus(1'b1, 4'h6, 32'h86);
        repeat (100) @(posedge clk_sys_i);
        cmp(dither_step_o, 4'h0);
        // presence drops while masked: flag must set, line must stay quiet
        run_clk <= 1'b0;
        repeat (200) @(posedge clk_sys_i);
        cmp(irq_o, 1'b0);
        rchk(4'h3, 32'h2);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        {avs_read_i, avs_write_i, run_clk, converter_enable_i, otp_fpwm1_i} = 5'h0;
        {avs_address_i, avs_writedata_i, load_code_i} = 45'h0;
        otp_fpwm0_i = 1'b1;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_boot();
        t_mode();
        t_meas();
        t_sync();
        t_pll_off();
        give_verdict();
    end
endmodule // tb_buck_clock_sync_and_load_meas
